/* File: logic/tdl_tap_chain.sv */
// Overview of operation
// (RL1) One scalar sample and enable in; a vector of delayed taps and valid out.
// (RL2) First stage zero or one cycle by parameter; further stages one-cycle holds.
// (RL3) One output element per stage, every tap visible at once.
// (RL4) Element zero is least delayed, unless reverse order puts most delayed first.
// (RL5) Upstream drives a scalar only; vector input is not supported.
// (RL6) Zero-latency first stage follows the input while enabled, same cycle.
// (RL7) Zero-latency first stage holds previous-cycle capture while enable is low.
// (RL8) Enable is a one-bit unsigned signal, driven at exactly that width.
// (RL9) One-cycle stage delays input one cycle when enabled, else holds output.
// (RL10) In one-cycle stages an enable change shows only from the next cycle.
// (RL11) Valid follows the enable through a delay matching the taps.
// (RL12) Reset clears all stages; valid stays low until the chain is filled.
module tdl_tap_chain
  import tdl_pkg::*;
#(
  parameter int DATA_W     = TDL_DEF_DATA_W,
  parameter int STAGES     = TDL_DEF_STAGES,
  parameter bit ZERO_FIRST = TDL_DEF_ZERO_FIRST,
  parameter bit REVERSE    = TDL_DEF_REVERSE
) (
  // Clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       rst_n,
  // Upstream sample
  input  wire logic [DATA_W-1:0]          din,
  input  wire logic [TDL_EN_W-1:0]        en,
  // Downstream taps
  output wire logic [STAGES*DATA_W-1:0]   taps_out,
  output wire logic                       taps_valid
);

  // Fill counter sizing; counts enabled samples taken since reset
  localparam int              FILL_W   = $clog2(STAGES + 1);
  localparam logic [FILL_W-1:0] FILL_NEED = FILL_W'(STAGES - 1);
  localparam logic [FILL_W-1:0] FILL_INC  = FILL_W'(TDL_FILL_STEP);

  logic [DATA_W-1:0] tap_val [STAGES];
  logic              en_on;
  logic              primed;
  logic [FILL_W-1:0] fill_reg;
  logic [FILL_W-1:0] fill_next;
  logic              valid_reg;
  logic              valid_next;

  // Enable decode, the single bit is the whole control
  assign en_on = (en == TDL_EN_ON);                                // RL8

  // Chain of hold stages, the head fed by din and each later one by the previous tap
  generate
    for (genvar k = 0; k < STAGES; k++) begin : g_stage
      if (k == 0) begin : g_head
        tdl_hold_stage #(
          .DATA_W   (DATA_W),
          .ZERO_LAT (ZERO_FIRST)
        ) u_first (
          .sys_clk (sys_clk),
          .rst_n   (rst_n),
          .hold_en (en),
          .din     (din),
          .q       (tap_val[k])
        );                                                         // RL2
      end else begin : g_body
        tdl_hold_stage #(
          .DATA_W   (DATA_W),
          .ZERO_LAT (1'b0)
        ) u_next (
          .sys_clk (sys_clk),
          .rst_n   (rst_n),
          .hold_en (en),
          .din     (tap_val[k-1]),
          .q       (tap_val[k])
        );                                                         // RL2
      end
    end
  endgenerate

  // Tap placement; reverse order only renames wires, costs no logic
  generate
    for (genvar k = 0; k < STAGES; k++) begin : g_place
      assign taps_out[k*DATA_W +: DATA_W] = tap_val[REVERSE ? (STAGES - 1 - k) : k];  // RL1 RL3 RL4
    end
  endgenerate

  // Primed once STAGES-1 enabled samples are in; the next enabled one fills the chain
  assign primed    = (fill_reg >= FILL_NEED);
  assign fill_next = (en_on && !primed) ? fill_reg + FILL_INC : fill_reg;
  assign valid_next = en_on && primed;

  // Fill counter saturates, so it never wraps back to unprimed
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fill_reg <= '0;                                              // RL12
    end else begin
      fill_reg <= fill_next;
    end
  end

  // Valid delay for the one-cycle head
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      valid_reg <= 1'b0;                                           // RL12
    end else begin
      valid_reg <= valid_next;                                     // RL11
    end
  end

  // Zero-latency head needs a same-cycle valid, hence the bypass
  assign taps_valid = ZERO_FIRST ? valid_next : valid_reg;         // RL11

  // Checks on the head stage
  a_head_pass: assert property (                                   // RL6
    @(posedge sys_clk) disable iff (!rst_n)
    (ZERO_FIRST && en_on) |-> (tap_val[0] == din))
    else $error("zero-latency head does not follow input");

  a_head_capture: assert property (                                // RL7
    @(posedge sys_clk) disable iff (!rst_n)
    (ZERO_FIRST && en_on) ##1 !en_on |-> (tap_val[0] == $past(din)))
    else $error("zero-latency head lost previous capture");

  a_head_keep: assert property (                                   // RL7
    @(posedge sys_clk) disable iff (!rst_n)
    (ZERO_FIRST && !en_on) ##1 !en_on |-> $stable(tap_val[0]))
    else $error("zero-latency head changed while disabled");

  a_unit_delay: assert property (                                  // RL9
    @(posedge sys_clk) disable iff (!rst_n)
    (!ZERO_FIRST && en_on) |=> (tap_val[0] == $past(din)))
    else $error("unit head not one cycle behind input");

  a_unit_late: assert property (                                   // RL10
    @(posedge sys_clk) disable iff (!rst_n)
    (!ZERO_FIRST && !en_on) ##1 en_on |-> $stable(tap_val[0]) ##1 (tap_val[0] == $past(din)))
    else $error("unit head reacted to enable too early");

  a_unit_hold: assert property (                                   // RL9
    @(posedge sys_clk) disable iff (!rst_n)
    (!ZERO_FIRST && !en_on) |=> $stable(tap_val[0]))
    else $error("unit head moved while disabled");

  // Each body stage shifts exactly one enabled step
  generate
    for (genvar k = 1; k < STAGES; k++) begin : g_chk
      a_chain_shift: assert property (                             // RL2
        @(posedge sys_clk) disable iff (!rst_n)
        en_on |=> (tap_val[k] == $past(tap_val[k-1])))
        else $error("body stage did not shift");

      a_chain_hold: assert property (                              // RL9
        @(posedge sys_clk) disable iff (!rst_n)
        !en_on |=> $stable(tap_val[k]))
        else $error("body stage moved while disabled");

      a_body_reset: assert property (                              // RL12
        @(posedge sys_clk)
        $rose(rst_n) |-> (tap_val[k] == '0))
        else $error("body stage not cleared by reset");
    end
  endgenerate

  a_order_map: assert property (                                   // RL4
    @(posedge sys_clk) disable iff (!rst_n)
    taps_out[DATA_W-1:0] == (REVERSE ? tap_val[STAGES-1] : tap_val[0]))
    else $error("tap order wrong at element zero");

  a_order_tail: assert property (                                  // RL4
    @(posedge sys_clk) disable iff (!rst_n)
    taps_out[STAGES*DATA_W-1 -: DATA_W] == (REVERSE ? tap_val[0] : tap_val[STAGES-1]))
    else $error("tap order wrong at last element");

  a_valid_gate: assert property (                                  // RL12
    @(posedge sys_clk) disable iff (!rst_n)
    (ZERO_FIRST ? !primed : !$past(primed)) |-> !taps_valid)
    else $error("valid before chain filled");

  a_valid_follow: assert property (                                // RL11
    @(posedge sys_clk) disable iff (!rst_n)
    (!ZERO_FIRST && en_on && primed) |=> taps_valid ##1 ($past(en_on) == taps_valid))
    else $error("valid does not track delayed enable");

  a_fill_step: assert property (                                   // RL12
    @(posedge sys_clk) disable iff (!rst_n)
    (en_on && !primed) |=> (fill_reg == $past(fill_reg) + FILL_INC))
    else $error("fill counter missed an enabled sample");

  // Fill counter stays in range and, once primed, never unprimes
  a_fill_bound: assert property (                                  // RL12
    @(posedge sys_clk) disable iff (!rst_n)
    fill_reg <= FILL_NEED)
    else $error("fill counter ran past its limit");

  a_fill_hold: assert property (                                   // RL12
    @(posedge sys_clk) disable iff (!rst_n)
    primed |=> primed)
    else $error("chain fell back to unprimed");

  // Valid drops with the enable; a held chain carries no fresh data
  a_valid_zero_off: assert property (                              // RL11
    @(posedge sys_clk) disable iff (!rst_n)
    (ZERO_FIRST && !en_on) |-> !taps_valid)
    else $error("same-cycle valid high while disabled");

  a_valid_unit_off: assert property (                              // RL11
    @(posedge sys_clk) disable iff (!rst_n)
    (!ZERO_FIRST && !en_on) |=> !taps_valid)
    else $error("registered valid high after disabled cycle");

  a_valid_cause: assert property (                                 // RL11
    @(posedge sys_clk) disable iff (!rst_n)
    (!ZERO_FIRST && taps_valid) |-> $past(en_on))
    else $error("registered valid without enabled edge");

  // Reset state, looked at on the first edge after release; edges inside
  // reset are skipped since the flops are unknown before the first one
  a_head_reset: assert property (                                  // RL12
    @(posedge sys_clk)
    ($rose(rst_n) && !(ZERO_FIRST && en_on)) |-> (tap_val[0] == '0))
    else $error("head stage not cleared by reset");

  a_valid_reset: assert property (                                 // RL12
    @(posedge sys_clk)
    $rose(rst_n) |-> !taps_valid)
    else $error("valid high straight after reset");

endmodule

/* File: logic/tdl_pkg.sv */
package tdl_pkg;

  // Default build shape of the tap chain
  localparam int TDL_DEF_DATA_W     = 8;
  localparam int TDL_DEF_STAGES     = 4;
  localparam bit TDL_DEF_ZERO_FIRST = 1'b0;
  localparam bit TDL_DEF_REVERSE    = 1'b0;

  // Width of the hold enable, a single unsigned bit
  localparam int TDL_EN_W = 1;

  // Level that opens a hold stage
  localparam logic TDL_EN_ON = 1'b1;

  // Hold stages clear to all zeros on reset
  localparam logic TDL_HOLD_RST = 1'b0;

  // Count step for the fill counter
  localparam int TDL_FILL_STEP = 1;

endpackage

/* File: logic/tdl_hold_stage.sv */
// One enable-gated hold stage. With ZERO_LAT set the stage is transparent
// while enabled and shows the last captured sample otherwise; with it clear
// the stage is a plain enabled register.
module tdl_hold_stage
  import tdl_pkg::*;
#(
  parameter int DATA_W   = TDL_DEF_DATA_W,
  parameter bit ZERO_LAT = 1'b0
) (
  // Clock and reset
  input  wire logic                sys_clk,
  input  wire logic                rst_n,
  // Sample path
  input  wire logic [TDL_EN_W-1:0] hold_en,
  input  wire logic [DATA_W-1:0]   din,
  output wire logic [DATA_W-1:0]   q
);

  logic [DATA_W-1:0] held_reg;
  logic [DATA_W-1:0] held_next;
  logic              open_w;

  // Same storage serves both flavours; only the output select differs
  assign open_w    = (hold_en == TDL_EN_ON);
  assign held_next = open_w ? din : held_reg;                      // RL9

  // Capture while open, keep otherwise
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      held_reg <= {DATA_W{TDL_HOLD_RST}};                          // RL12
    end else begin
      held_reg <= held_next;                                       // RL10
    end
  end

  // Zero latency: pass through while open, else last capture
  assign q = (ZERO_LAT && open_w) ? din : held_reg;                // RL6 RL7

endmodule

/* File: testbench/tdl_upstream.sv */
// Upstream sample source for the tap chain
module tdl_upstream
  import tdl_pkg::*;
#(
  parameter int DATA_W = TDL_DEF_DATA_W
) (
  // Clock
  input  wire logic                sys_clk,
  // Enable pattern: 0 off, 3 on, else random
  input  wire logic [1:0]          en_mode,
  // Sample to the chain
  output      logic [DATA_W-1:0]   din,
  output      logic [TDL_EN_W-1:0] en
);
  timeunit 1ns;
  timeprecision 1ps;

  bit seeded = 1'b0;

  // Falling-edge launch keeps the rising edge free of races; the seed is
  // taken here so that this process's own random stream is the fixed one
  always @(negedge sys_clk) begin
    if (!seeded) begin
      void'($urandom(32'h597e_cab9));
      seeded = 1'b1;
    end
    din <= DATA_W'($urandom);
    en  <= en_mode == 2'h3 || (en_mode != 2'h0 && $urandom_range(32'(en_mode)) != 0);
  end
endmodule

/* File: testbench/testbench.sv */
module testbench;
  import tdl_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int W = 8;
  localparam int N = 4;
  logic                  sys_clk = 1'b0;
  logic                  rst_n   = 1'b0;
  logic [1:0]            en_mode = 2'h0;
  wire logic [W-1:0]     din;
  wire logic [0:0]       en;
  wire logic [N*W-1:0]   taps_a;
  wire logic [N*W-1:0]   taps_b;
  wire logic             va;
  wire logic             vb;
  logic [W-1:0]          r [N];
  int                    cnt = 0;
  logic                  vreg = 1'b0;
  logic [2*N*W+1:0]      q [$];
  logic [2*N*W+1:0]      note;
  int                    n_mismatch = 0;
  int                    comparisons = 0;

  always #10 sys_clk = ~sys_clk;

  tdl_upstream #(.DATA_W(W)) tdl_upstream_inst (.sys_clk(sys_clk), .en_mode(en_mode), .din(din), .en(en));
  // Registered head, forward order
  tdl_tap_chain #(.DATA_W(W), .STAGES(N), .ZERO_FIRST(1'b0), .REVERSE(1'b0)) tdl_tap_chain_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .din(din), .en(en), .taps_out(taps_a), .taps_valid(va));
  // Transparent head, reversed order
  tdl_tap_chain #(.DATA_W(W), .STAGES(N), .ZERO_FIRST(1'b1), .REVERSE(1'b1)) tdl_tap_chain_zr_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .din(din), .en(en), .taps_out(taps_b), .taps_valid(vb));

  // Expected view of both chains from the shadow holds
  function automatic logic [2*N*W+1:0] expect_now();
    logic [N*W-1:0] a;
    logic [N*W-1:0] b;
    for (int k = 0; k < N; k++) begin
      a[k*W +: W] = r[k];
      b[(N-1-k)*W +: W] = (k == 0) ? (en == TDL_EN_ON ? din : r[0]) : r[k-1];
    end
    return {vreg, en == TDL_EN_ON && cnt >= N-1, a, b};
  endfunction

  // Tap vectors of both chains, registered head first
  task automatic check_taps(input logic [2*N*W-1:0] got, input logic [2*N*W-1:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t taps got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Valid pair of both chains, registered head in the upper bit
  task automatic check_valid(input logic [1:0] got, input logic [1:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t valid got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Shadow update for the edge just past, then new inputs and a note
  task automatic step(input int cyc, input logic [1:0] mode, input logic hold_rst);
    repeat (cyc) begin
      @(negedge sys_clk);
      if (rst_n) begin
        vreg = en == TDL_EN_ON && cnt >= N-1;
        if (en == TDL_EN_ON) begin
          for (int k = N-1; k > 0; k--) r[k] = r[k-1];
          r[0] = din;
          if (cnt < N-1) cnt++;
        end
      end
      rst_n = !hold_rst;
      if (hold_rst) begin
        foreach (r[k]) r[k] = '0;
        cnt = 0;
        vreg = 1'b0;
      end
      en_mode <= mode;
      #1 q.push_back(expect_now());
    end
  endtask

  task automatic final_report();
    $display("comparisons=%0d n_mismatch=%0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Compare every cycle; combinational taps are settled since the falling edge
  always @(posedge sys_clk) begin
    if (q.size() > 0) begin
      note = q.pop_front();
      check_taps({taps_a, taps_b}, note[2*N*W-1:0]);
      check_valid({va, vb}, note[2*N*W+1 -: 2]);
    end
  end

  // Main sequence: reset, fill, random enable, hold, mid-run reset, denser random enable
  initial begin
    foreach (r[k]) r[k] = '0;
    step(20, 2'h0, 1'b1);
    step(8, 2'h3, 1'b0);
    step(60, 2'h1, 1'b0);
    step(5, 2'h0, 1'b0);
    step(3, 2'h3, 1'b1);
    step(60, 2'h2, 1'b0);
    final_report();
  end

  // Hang guard, far beyond the 156 cycles planned
  initial begin
    #100us;
    n_mismatch++;
    final_report();
  end
endmodule
